/* rtl/sct_fifo.sv */
`timescale 1ns/100ps
// small synchronous fifo; words live in a register array
module sct_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling and draining sides
   sct_stream_if.snk inPort,
   sct_stream_if.src outPort
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [W-1:0] mem [DEPTH]; // storage words
   logic [PTR_W-1:0] wrPtr; // next slot to write
   logic [PTR_W-1:0] rdPtr; // oldest word
   logic [CNT_W-1:0] fill; // words held
   wire push = inPort.valid && inPort.ready;
   wire pop = outPort.valid && outPort.ready;

   // pointer wrap, also fine for depths that are not a power of two
   function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
      return (p == PTR_LAST) ? '0 : p + PTR_W'(1);
   endfunction

   // honest flags straight from the fill count
   assign inPort.ready = (fill != CNT_FULL);
   assign outPort.valid = (fill != '0);
   assign outPort.data = mem[rdPtr];

   // storage needs no reset, nothing reads an empty slot
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inPort.data;
      end
   end

   // pointers and count
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wrPtr <= nextPtr(wrPtr);
         end
         if (pop) begin
            rdPtr <= nextPtr(rdPtr);
         end
         if (push && !pop) begin
            fill <= fill + CNT_ONE;
         end else if (pop && !push) begin
            fill <= fill - CNT_ONE;
         end
      end
   end
endmodule

/* rtl/sct_pkg.sv */
package sct_pkg;
   // clock and bus timing, all times in nanoseconds
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_SETTLE_NS = 400;
   localparam int DESKEW_NS = 45;
   localparam int CABLE_SKEW_NS = 10;
   // least times round up to whole cycles
   localparam int SETTLE_CYC = (BUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (DESKEW_NS + CABLE_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // settle timer; the setup time is shorter and is covered by the same wait
   localparam int TIMER_W = 6;
   localparam logic [TIMER_W-1:0] SETTLE_LAST = TIMER_W'(SETTLE_CYC - 1);
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 6'h00;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 6'h01;
   // command byte counter
   localparam int CMD_CNT_W = 4;
   localparam logic [CMD_CNT_W-1:0] CMD_CNT_ZERO = 4'h0;
   localparam logic [CMD_CNT_W-1:0] CMD_CNT_ONE = 4'h1;
   // bus data width and user fifo depth
   localparam int BUS_W = 8;
   localparam int FIFO_DEPTH = 4;
   // released bus level and cleared byte, the reset values of the byte outputs
   localparam logic [BUS_W-1:0] BUS_RELEASED_N = 8'hFF;
   localparam logic [BUS_W-1:0] BYTE_CLEAR = 8'h00;
   // target sequencer, one-hot
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_SELECTED = 10'h002,
      ST_CMD_SETTLE = 10'h004,
      ST_CMD_WAIT = 10'h008,
      ST_CMD_REQ = 10'h010,
      ST_CMD_REL = 10'h020,
      ST_STAT_WAIT = 10'h040,
      ST_STAT_SETUP = 10'h080,
      ST_STAT_REQ = 10'h100,
      ST_STAT_REL = 10'h200
   } sct_state_t;
endpackage

/* rtl/sct_stream_if.sv */
`timescale 1ns/100ps
// valid/ready byte stream between the sequencer and the fifo
interface sct_stream_if #(parameter int W = 8) ();
   logic valid; // source has a word
   logic ready; // sink takes it this cycle
   logic [W-1:0] data; // the word
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* rtl/sct_target.sv */
`timescale 1ns/100ps
module sct_target import sct_pkg::*; #(
   parameter int CMD_BYTES = 6,
   parameter logic [2:0] TARGET_ID = 3'h0 // arbitrary default bus id
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // scsi lines driven by the initiator, active low, asynchronous
   input wire logic selN,
   input wire logic ackN,
   // busy line, open drain
   input wire logic bsyInN,
   output logic bsyOutN,
   output logic bsyOe,
   // data lines, two-way, active low
   input wire logic [BUS_W-1:0] dataInN,
   output logic [BUS_W-1:0] dataOutN,
   output logic dataOe,
   // phase and handshake lines driven only by the target
   output logic cdN,
   output logic ioN,
   output logic reqN,
   // user side: one strobe, request-to-send and clear-to-send
   input wire logic hostDataStrobeN,
   input wire logic [BUS_W-1:0] hostData,
   output logic [BUS_W-1:0] cmdData,
   output logic cmdRts,
   output logic statusCts
);
   localparam int SYNC_W = BUS_W + 3;
   localparam logic [CMD_CNT_W-1:0] CMD_LAST = CMD_CNT_W'(CMD_BYTES - 1);
   localparam logic [CMD_CNT_W-1:0] CMD_TOTAL = CMD_CNT_W'(CMD_BYTES);

   // two-stage synchronisers; only the second stage is looked at
   logic [SYNC_W-1:0] syncA;
   logic [SYNC_W-1:0] syncB;
   always_ff @(posedge clk) begin
      syncA <= {bsyInN, selN, ackN, dataInN};
      syncB <= syncA;
   end

   // bus levels in asserted-high sense
   wire busBsy = !syncB[SYNC_W-1];
   wire busSel = !syncB[SYNC_W-2];
   wire busAck = !syncB[SYNC_W-3];
   wire [BUS_W-1:0] busData = ~syncB[BUS_W-1:0];

   sct_state_t state; // sequencer state
   sct_state_t next_state; // its next value
   logic [TIMER_W-1:0] timer; // cycles spent in the current state
   logic [CMD_CNT_W-1:0] cmdCount; // command bytes taken this selection

   // command bytes flow to the user through a small fifo
   sct_stream_if #(.W(BUS_W)) pushIf ();
   sct_stream_if #(.W(BUS_W)) popIf ();
   sct_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) cmdFifo (
      .clk(clk),
      .rst(rst),
      .inPort(pushIf),
      .outPort(popIf)
   );

   // decodes
   wire selHit = busSel && !busBsy && busData[TARGET_ID];
   wire settleDone = (timer == SETTLE_LAST);
   wire lastCmd = (cmdCount == CMD_LAST);
   wire takeCmd = !hostDataStrobeN && cmdRts;
   wire loadStatus = !hostDataStrobeN && statusCts && !cmdRts;
   // byte is pushed on the synced ack; data was set up before ack, so the
   // twin synchroniser delay keeps them aligned
   assign pushIf.valid = (state == ST_CMD_REQ) && busAck;
   assign pushIf.data = busData;
   // drain into the output stage whenever it is empty or being emptied
   assign popIf.ready = !cmdRts || takeCmd;

   // next-state selection
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (selHit) begin
               next_state = ST_SELECTED;
            end
         end
         ST_SELECTED: begin
            // wait for the initiator to let go of select
            if (!busSel) begin
               next_state = ST_CMD_SETTLE;
            end
         end
         ST_CMD_SETTLE: begin
            if (settleDone) begin
               next_state = ST_CMD_WAIT;
            end
         end
         ST_CMD_WAIT: begin
            // request only when the fifo can take the byte, and after the
            // previous ack is gone
            if (pushIf.ready && !busAck) begin
               next_state = ST_CMD_REQ;
            end
         end
         ST_CMD_REQ: begin
            if (busAck) begin
               next_state = ST_CMD_REL;
            end
         end
         ST_CMD_REL: begin
            if (!busAck) begin
               next_state = lastCmd ? ST_STAT_WAIT : ST_CMD_WAIT;
            end
         end
         ST_STAT_WAIT: begin
            if (loadStatus) begin
               next_state = ST_STAT_SETUP;
            end
         end
         ST_STAT_SETUP: begin
            // settle covers the shorter data setup as well
            if (settleDone) begin
               next_state = ST_STAT_REQ;
            end
         end
         ST_STAT_REQ: begin
            if (busAck) begin
               next_state = ST_STAT_REL;
            end
         end
         ST_STAT_REL: begin
            if (!busAck) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE; // broken one-hot code recovers
         end
      endcase
   end

   // output decodes from the next state, so every pin is a flop
   wire next_busy = (next_state != ST_IDLE);
   wire next_cmdPhase = (next_state == ST_CMD_SETTLE) || (next_state == ST_CMD_WAIT)
      || (next_state == ST_CMD_REQ) || (next_state == ST_CMD_REL);
   wire next_statPhase = (next_state == ST_STAT_SETUP) || (next_state == ST_STAT_REQ)
      || (next_state == ST_STAT_REL);
   wire next_req = (next_state == ST_CMD_REQ) || (next_state == ST_STAT_REQ);

   // state, timer and byte count
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         timer <= TIMER_ZERO;
         cmdCount <= CMD_CNT_ZERO;
      end else begin
         state <= next_state;
         timer <= (state != next_state) ? TIMER_ZERO : timer + TIMER_ONE;
         if (state == ST_IDLE) begin
            cmdCount <= CMD_CNT_ZERO;
         end else if (state == ST_CMD_REL && !busAck) begin
            cmdCount <= cmdCount + CMD_CNT_ONE;
         end
      end
   end

   // scsi pins; reset releases everything
   always_ff @(posedge clk) begin
      if (rst) begin
         bsyOe <= 1'h0;
         bsyOutN <= 1'h1;
         cdN <= 1'h1;
         ioN <= 1'h1;
         reqN <= 1'h1;
         dataOe <= 1'h0;
      end else begin
         bsyOe <= next_busy;
         bsyOutN <= !next_busy;
         cdN <= !(next_cmdPhase || next_statPhase);
         ioN <= !next_statPhase;
         reqN <= !next_req;
         dataOe <= next_statPhase;
      end
   end

   // status byte is held from the strobe until the next one
   always_ff @(posedge clk) begin
      if (rst) begin
         dataOutN <= BUS_RELEASED_N;
      end else if (loadStatus) begin
         dataOutN <= ~hostData;
      end
   end

   // user side: rts while a command byte waits, cts while status is wanted
   always_ff @(posedge clk) begin
      if (rst) begin
         cmdRts <= 1'h0;
         cmdData <= BYTE_CLEAR;
         statusCts <= 1'h0;
      end else begin
         if (popIf.valid && popIf.ready) begin
            cmdRts <= 1'h1;
            cmdData <= popIf.data;
         end else if (takeCmd) begin
            cmdRts <= 1'h0;
         end
         statusCts <= (next_state == ST_STAT_WAIT);
      end
   end

   // helper: bytes pushed since selection
   logic [CMD_CNT_W-1:0] pushTotal;
   always_ff @(posedge clk) begin
      if (rst || state == ST_IDLE) begin
         pushTotal <= CMD_CNT_ZERO;
      end else if (pushIf.valid && pushIf.ready) begin
         pushTotal <= pushTotal + CMD_CNT_ONE;
      end
   end

   property p_bsy_answer;
      @(posedge clk) disable iff (rst) (state == ST_IDLE && selHit) |=> bsyOe;
   endproperty
   a_bsy_answer: assert property (p_bsy_answer) else $error("busy not driven after select");
   property p_sel_fast;
      @(posedge clk) disable iff (rst) $rose(busSel && busData[TARGET_ID] && !busBsy)
         |-> ##[1:3] bsyOe;
   endproperty
   a_sel_fast: assert property (p_sel_fast) else $error("selection answer too slow");
   property p_cmd_req;
      @(posedge clk) disable iff (rst) (!reqN && state == ST_CMD_REQ) |-> (!cdN && ioN);
   endproperty
   a_cmd_req: assert property (p_cmd_req) else $error("command req without c/d");
   property p_req_drop;
      @(posedge clk) disable iff (rst) (state == ST_CMD_REQ && busAck) |=> reqN;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("req held after byte taken");
   property p_six_bytes;
      @(posedge clk) disable iff (rst) $rose(state == ST_STAT_WAIT) |-> pushTotal == CMD_TOTAL;
   endproperty
   a_six_bytes: assert property (p_six_bytes) else $error("wrong command byte count");
   property p_status;
      @(posedge clk) disable iff (rst) (!reqN && !ioN) |-> (!cdN && dataOe);
   endproperty
   a_status: assert property (p_status) else $error("status req without c/d or data");
   property p_bsy_end;
      @(posedge clk) disable iff (rst) $fell(bsyOe) |-> ($past(state) == ST_STAT_REL);
   endproperty
   a_bsy_end: assert property (p_bsy_end) else $error("busy dropped before status end");
   property p_data_setup;
      @(posedge clk) disable iff (rst) ($fell(reqN) && !ioN) |-> $past(dataOe, SETUP_CYC);
   endproperty
   a_data_setup: assert property (p_data_setup) else $error("status data setup short");
   property p_settle;
      @(posedge clk) disable iff (rst) $fell(reqN) |-> !$past(cdN, SETTLE_CYC);
   endproperty
   a_settle: assert property (p_settle) else $error("c/d not settled before req");
   property p_rts_hold;
      @(posedge clk) disable iff (rst) (cmdRts && hostDataStrobeN) |=> cmdRts && $stable(cmdData);
   endproperty
   a_rts_hold: assert property (p_rts_hold) else $error("rts dropped without strobe");
endmodule

/* verification/scsi_initiator_handshake_tb_top.sv */
`timescale 1ns/100ps
// self-checking bench: initiator model on the bus, user port driven here
module scsi_initiator_handshake_tb_top import sct_pkg::*; ;
   localparam logic [2:0] TB_ID = 3'h5; // non-default id on purpose
   // clock, reset and user side
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hostDataStrobeN = 1'b1;
   logic [BUS_W-1:0] hostData = 8'h00;
   // lines from the initiator model
   wire logic selN, ackN, iOe;
   wire logic [BUS_W-1:0] iDataN;
   // target outputs
   wire logic bsyOutN, bsyOe, dataOe, cdN, ioN, reqN, cmdRts, statusCts;
   wire logic [BUS_W-1:0] dataOutN, cmdData;
   // bus levels; terminator pull-ups win when nobody drives
   wire logic bsyWireN = bsyOe ? bsyOutN : 1'b1;
   wire logic [BUS_W-1:0] busN = dataOe ? dataOutN : (iOe ? iDataN : 8'hFF);
   int err_count = 0; // mismatches
   int n_checks = 0; // comparisons made
   int cycles = 0; // run length for the timeout
   sct_target #(.CMD_BYTES(6), .TARGET_ID(TB_ID)) uut (
      .clk(clk), .rst(rst), .selN(selN), .ackN(ackN),
      .bsyInN(bsyWireN), .bsyOutN(bsyOutN), .bsyOe(bsyOe),
      .dataInN(busN), .dataOutN(dataOutN), .dataOe(dataOe),
      .cdN(cdN), .ioN(ioN), .reqN(reqN),
      .hostDataStrobeN(hostDataStrobeN), .hostData(hostData),
      .cmdData(cmdData), .cmdRts(cmdRts), .statusCts(statusCts)
   );
   sct_init_model ini (
      .clk(clk), .bsyN(bsyWireN), .reqN(reqN), .busN(busN),
      .selN(selN), .ackN(ackN), .dataN(iDataN), .dataOe(iOe)
   );
   // free-running clock
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         $display("timeout at %0t", $time);
         summarize();
      end
   end
   // one comparison, four-state exact
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // all lines released and user port idle after reset
   task automatic t_reset();
      check({bsyOe, bsyOutN, cdN, ioN, reqN, dataOe, cmdRts, statusCts}, 8'h78);
      check(dataOutN, 8'hFF);
      check(cmdData, 8'h00);
      $display("test reset done");
   endtask
   // selection of another id must be ignored
   task automatic t_wrong_id();
      ini.select(3'h2);
      check({7'h00, bsyOe}, 8'h00);
      $display("test wrong id done");
   endtask
   // selection, six command bytes, user port stalls first
   task automatic t_command();
      logic [BUS_W-1:0] cmd [6];
      int tmo;
      cmd = '{8'h12, 8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h81};
      ini.select(TB_ID);
      check({7'h00, bsyOe}, 8'h01);
      fork
         begin
            for (int i = 0; i < 6; i++) ini.send_cmd(cmd[i]);
         end
         begin
            // fifo full: req must be withheld while control phase stands
            repeat (300) @(posedge clk);
            check({6'h00, reqN, cdN}, 8'h02);
            check({7'h00, ini.acked < 6}, 8'h01);
            for (int i = 0; i < 6; i++) begin
               tmo = 0;
               do begin
                  @(posedge clk);
                  tmo++;
               end while (cmdRts !== 1'b1 && tmo < 500);
               check(cmdData, cmd[i]);
               hostDataStrobeN <= 1'b0;
               @(posedge clk);
               hostDataStrobeN <= 1'b1;
            end
         end
      join
      check(8'(ini.acked), 8'h06);
      $display("test command done");
   endtask
   // status load, settle before req, status handshake, busy off
   task automatic t_status();
      logic [BUS_W-1:0] got;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (statusCts !== 1'b1 && n < 100);
      check({6'h00, cmdRts, statusCts}, 8'h01);
      hostData <= 8'hC3;
      hostDataStrobeN <= 1'b0;
      @(posedge clk);
      hostDataStrobeN <= 1'b1;
      @(posedge clk);
      check({4'h0, statusCts, dataOe, cdN, ioN}, 8'h04);
      check(dataOutN, 8'h3C);
      // edges from phase lines set until req, at least one settle delay
      for (n = 1; reqN !== 1'b0 && n < 200; n++) @(posedge clk);
      check({7'h00, n > SETTLE_CYC}, 8'h01);
      ini.read_status(got);
      check(got, 8'hC3);
      for (n = 0; bsyOe !== 1'b0 && n < 20; n++) @(posedge clk);
      check({5'h00, bsyOe, cdN, ioN}, 8'h03);
      $display("test status done");
   endtask
   // reset in mid-selection must release every line, checked one edge after reset ends
   task automatic t_mid_reset();
      ini.select(TB_ID);
      rst <= 1'b1;
      // three edges also flush the synchronisers
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({bsyOe, bsyOutN, cdN, ioN, reqN, dataOe, cmdRts, statusCts}, 8'h78);
      $display("test mid reset done");
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_wrong_id();
      t_command();
      t_status();
      t_mid_reset();
      summarize();
   end
endmodule

/* verification/sct_init_model.sv */
`timescale 1ns/100ps
// behavioural initiator facing the target; the bench calls its tasks
module sct_init_model import sct_pkg::*; (
   // clock
   input wire logic clk,
   // resolved lines coming from the target
   input wire logic bsyN,
   input wire logic reqN,
   input wire logic [BUS_W-1:0] busN,
   // lines driven here, each from a register
   output logic selN,
   output logic ackN,
   output logic [BUS_W-1:0] dataN,
   output logic dataOe
);
   int acked = 0; // command bytes completed
   int tmo; // bound on every wait, so a dead target cannot hang the run
   // lines idle from time zero
   initial begin
      selN = 1'b1;
      ackN = 1'b1;
      dataN = 8'hFF;
      dataOe = 1'b0;
   end
   // free bus, settle, select with one id line, let go after busy
   task automatic select(input logic [2:0] id);
      for (tmo = 0; bsyN !== 1'b1 && tmo < 1000; tmo++) @(posedge clk);
      repeat (SETTLE_CYC) @(posedge clk);
      selN <= 1'b0;
      dataN <= ~(8'h01 << id);
      dataOe <= 1'b1;
      for (tmo = 0; bsyN !== 1'b0 && tmo < 50; tmo++) @(posedge clk);
      repeat (2 * DESKEW_NS / CLK_PERIOD_NS + 1) @(posedge clk);
      selN <= 1'b1;
      dataOe <= 1'b0;
   endtask
   // one command byte: data first, ack after setup, ack held until req drops
   task automatic send_cmd(input logic [BUS_W-1:0] b);
      for (tmo = 0; reqN !== 1'b0 && tmo < 1000; tmo++) @(posedge clk);
      dataN <= ~b;
      dataOe <= 1'b1;
      repeat (SETUP_CYC) @(posedge clk);
      ackN <= 1'b0;
      for (tmo = 0; reqN !== 1'b1 && tmo < 1000; tmo++) @(posedge clk);
      ackN <= 1'b1;
      dataOe <= 1'b0;
      acked++;
   endtask
   // status byte, taken while req is low
   task automatic read_status(output logic [BUS_W-1:0] b);
      for (tmo = 0; reqN !== 1'b0 && tmo < 1000; tmo++) @(posedge clk);
      b = ~busN;
      ackN <= 1'b0;
      for (tmo = 0; reqN !== 1'b1 && tmo < 1000; tmo++) @(posedge clk);
      ackN <= 1'b1;
   endtask
endmodule
